// >>> design/fault_alert_pkg.sv
// Constants, register map and carrier types of the supervisor
package fault_alert_pkg;

  // System clock and low-frequency timebase
  localparam int CLK_HZ = 10_000_000;
  localparam int LF_CLK_HZ = 32_768;
  localparam int LF_DIV_CYC = CLK_HZ / LF_CLK_HZ;

  // Least times round up to whole ticks
  localparam int DEGLITCH_US = 125;
  localparam int OT_BLANK_US = 300;
  localparam int SETTLE_MS = 10;
  localparam int CHECK_PERIOD_S = 1;
  localparam int DEGLITCH_TICKS = (DEGLITCH_US * LF_CLK_HZ + 999_999) / 1_000_000;
  localparam int OT_BLANK_TICKS = (OT_BLANK_US * LF_CLK_HZ + 999_999) / 1_000_000;
  localparam int SETTLE_TICKS = (SETTLE_MS * LF_CLK_HZ + 999) / 1_000;
  localparam int CHECK_TICKS = CHECK_PERIOD_S * LF_CLK_HZ;

  // Slave addresses by select pin
  localparam logic [6:0] I2C_ADDR_LOW = 7'h3F;
  localparam logic [6:0] I2C_ADDR_HIGH = 7'h2A;

  // Register offsets
  localparam logic [7:0] OFS_DEVICE_INFORMATION = 8'h00;
  localparam logic [7:0] OFS_LATCHED_FAULT_FLAGS = 8'h01;
  localparam logic [7:0] OFS_SECONDARY_FLAGS = 8'h02;
  localparam logic [7:0] OFS_INTERRUPT_MASK = 8'h03;
  localparam logic [7:0] OFS_CONFIGURATION_A = 8'h04;
  localparam logic [7:0] OFS_CONFIGURATION_B = 8'h05;
  localparam logic [7:0] OFS_BLOCK_ENABLES_A = 8'h06;
  localparam logic [7:0] OFS_BLOCK_ENABLES_B = 8'h07;
  localparam logic [7:0] OFS_CONTROL_BITS = 8'h08;

  // Field positions
  localparam int BIT_FLAG_OVERTEMP = 0;
  localparam int BIT_FLAG_HOST_LDO = 1;
  localparam int BIT_CFGA_ALERT_ON_RX = 0;
  localparam int BIT_CFGA_LDO_FAULT_DIS = 1;
  localparam int BIT_ENB_HOST_REGULATOR = 0;
  localparam int BIT_ENB_OVERTEMP_MON = 1;
  localparam logic [1:0] GPIO_FUNC_ALERT = 2'h2;

  // Reset values
  localparam logic [7:0] RST_INTERRUPT_MASK = 8'h00;
  localparam logic [7:0] RST_CONFIGURATION_A = 8'h00;
  localparam logic [7:0] RST_CONFIGURATION_B = 8'h00;
  localparam logic [7:0] RST_BLOCK_ENABLES_A = 8'h00;
  localparam logic [7:0] RST_BLOCK_ENABLES_B = 8'h01;
  localparam logic [7:0] RST_CONTROL_BITS = 8'h00;

  // Register access from the serial port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef enum logic [1:0] {FS_NORMAL, FS_LDO_FAULT, FS_OVERTEMP} fault_state_t;

endpackage

// >>> design/i2c_reg_slave.sv
// Two-wire slave with auto-incrementing register pointer
module i2c_reg_slave
(
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic [6:0] slave_addr_in,
  input wire logic [7:0] rdata_in,
  output fault_alert_pkg::reg_req_t req_out,
  output logic sda_oe_b_out
);
  import fault_alert_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_ACK_ADDR, S_WR_BYTE, S_ACK_WR, S_RD_BYTE,
    S_ACK_RD} i2c_state_t;

  i2c_state_t state_reg;
  logic scl_d_reg;
  logic sda_d_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic [7:0] ptr_reg;
  logic [3:0] cnt_reg;
  logic rw_reg;
  logic first_reg;
  logic nack_reg;
  logic start_det;
  logic stop_det;
  logic scl_rise;
  logic scl_fall;

  ////////////////////////////////////////////////////////////////////////////
  // Start, stop and clock edges on filtered lines
  always_ff @(posedge sys_clk_in)
  begin
    scl_d_reg <= scl_in;
    sda_d_reg <= sda_in;
  end

  assign start_det = scl_in && scl_d_reg && sda_d_reg && !sda_in;
  assign stop_det = scl_in && scl_d_reg && !sda_d_reg && sda_in;
  assign scl_rise = scl_in && !scl_d_reg;
  assign scl_fall = !scl_in && scl_d_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Byte engine; pointer steps each data byte
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      state_reg <= S_IDLE;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      ptr_reg <= 8'h00;
      cnt_reg <= 4'h0;
      rw_reg <= 1'b0;
      first_reg <= 1'b0;
      nack_reg <= 1'b0;
    end
    else if (start_det)
    begin
      state_reg <= S_ADDR;
      cnt_reg <= 4'h0;
    end
    else if (stop_det)
      state_reg <= S_IDLE;
    else if (scl_rise)
    begin
      unique case (state_reg)
        S_ADDR, S_WR_BYTE:
        begin
          shift_reg <= {shift_reg[6:0], sda_in};
          cnt_reg <= cnt_reg + 4'h1;
        end
        S_RD_BYTE: cnt_reg <= cnt_reg + 4'h1;
        S_ACK_RD: nack_reg <= sda_in;
        S_IDLE, S_ACK_ADDR, S_ACK_WR: ;
      endcase
    end
    else if (scl_fall)
    begin
      unique case (state_reg)
        S_ADDR:
          if (cnt_reg == 4'h8)
          begin
            // Own address only
            state_reg <= (shift_reg[7:1] == slave_addr_in) ? S_ACK_ADDR : S_IDLE;
            rw_reg <= shift_reg[0];
          end
        S_ACK_ADDR:
        begin
          cnt_reg <= 4'h0;
          first_reg <= 1'b1;
          if (rw_reg)
          begin
            state_reg <= S_RD_BYTE;
            tx_reg <= rdata_in;
            ptr_reg <= ptr_reg + 8'h01;
          end
          else
            state_reg <= S_WR_BYTE;
        end
        S_WR_BYTE:
          if (cnt_reg == 4'h8)
          begin
            state_reg <= S_ACK_WR;
            first_reg <= 1'b0;
            ptr_reg <= first_reg ? shift_reg : ptr_reg + 8'h01;
          end
        S_ACK_WR:
        begin
          state_reg <= S_WR_BYTE;
          cnt_reg <= 4'h0;
        end
        S_RD_BYTE:
          if (cnt_reg == 4'h8)
            state_reg <= S_ACK_RD;
          else
            tx_reg <= {tx_reg[6:0], 1'b0};
        S_ACK_RD:
          if (nack_reg)
            state_reg <= S_IDLE; // Nack ends the read
          else
          begin
            state_reg <= S_RD_BYTE;
            tx_reg <= rdata_in;
            ptr_reg <= ptr_reg + 8'h01;
            cnt_reg <= 4'h0;
          end
        S_IDLE: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register strobes; a read marks the byte fetched
  always_comb
  begin
    req_out.addr = ptr_reg;
    req_out.wdata = shift_reg;
    req_out.wr = scl_fall && !start_det && !stop_det && state_reg == S_WR_BYTE
      && cnt_reg == 4'h8 && !first_reg;
    req_out.rd = scl_fall && !start_det && !stop_det
      && ((state_reg == S_ACK_ADDR && rw_reg) || (state_reg == S_ACK_RD && !nack_reg));
  end

  // Open drain: enable low pulls low
  assign sda_oe_b_out = !(state_reg == S_ACK_ADDR || state_reg == S_ACK_WR
    || (state_reg == S_RD_BYTE && !tx_reg[7]));

endmodule

// >>> design/fault_alert_supervisor.sv
// Fault flags, alert routing, fault states and register file
//
// Behaviour
// - Flags latch high on condition and stay
// - Mask bit gates each flag onto alert
// - Alert on general pin when select 0x2
// - Alert on receive pin when bit set
// - Flag read clears only cleared conditions
// - Power-good deglitched 125 us while regulator on
// - Latch regulator error after 10 ms settling
// - Error bit without disable enters regulator fault
// - Regulator fault: blocks off, regulator, monitor on
// - Each second exit if power-good high
// - Flag read with power-good high exits
// - Exit restores enables saved at entry
// - Overtemp in regulator fault, return after
// - Overtemp above 125 degrees, 300 us blanking
// - Overtemp turns everything off, sets error
// - Exit overtemp when below 110 degrees
// - Serial slave with auto-incrementing pointer
// - Address 0x3F low, 0x2A high select
module fault_alert_supervisor
#(
  parameter int LF_DIV = fault_alert_pkg::LF_DIV_CYC,
  parameter int SETTLE_TICKS = fault_alert_pkg::SETTLE_TICKS,
  parameter int CHECK_TICKS = fault_alert_pkg::CHECK_TICKS,
  parameter logic [7:0] DEVICE_INFO = 8'h5A // Arbitrary identification value
)
(
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_b_out,
  input wire logic address_select_pin_in,
  input wire logic host_ldo_uv_ok_in,
  input wire logic die_above_125_in,
  input wire logic die_below_110_in,
  input wire logic [5:0] ext_fault_cond_in,
  output logic gpio_alert_out,
  output logic rx_pin_alert_out,
  output logic [7:0] block_enables_a_out,
  output logic [7:0] block_enables_b_out,
  output logic [2:0] host_ldo_vsel_out,
  output fault_alert_pkg::fault_state_t fault_state_out
);
  import fault_alert_pkg::*;

  if (LF_DIV < 2 || LF_DIV > 65535 || SETTLE_TICKS < 1 || SETTLE_TICKS > 65535
      || CHECK_TICKS < 1 || CHECK_TICKS > 65535)
  begin : g_param_check
    $error("fault_alert_supervisor: timing parameter out of range");
  end

  localparam logic [15:0] LF_DIV_L = 16'(LF_DIV - 1);
  localparam logic [15:0] SETTLE_L = 16'(SETTLE_TICKS);
  localparam logic [15:0] CHECK_L = 16'(CHECK_TICKS - 1);
  localparam logic [15:0] DEGLITCH_L = 16'(DEGLITCH_TICKS);
  localparam logic [15:0] BLANK_L = 16'(OT_BLANK_TICKS);

  // Synchroniser bank pin index
  localparam int PIN_SCL = 0;
  localparam int PIN_SDA = 1;
  localparam int PIN_ASEL = 2;
  localparam int PIN_PG = 3;
  localparam int PIN_HOT = 4;
  localparam int PIN_COOL = 5;

  logic [5:0] sync1_reg;
  logic [5:0] sync2_reg;
  logic [5:0] sync3_reg;
  logic [5:0] pin_reg;
  logic [15:0] div_reg;
  logic lf_tick;
  reg_req_t req;
  logic [7:0] rdata;
  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  logic [7:0] flag_set;
  logic [7:0] flag_cond;
  logic [7:0] mask_reg;
  logic [7:0] cfg_a_reg;
  logic [7:0] cfg_b_reg;
  logic [7:0] en_a_reg;
  logic [7:0] en_b_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] saved_a_reg;
  logic [7:0] saved_b_reg;
  fault_state_t state_reg;
  logic from_ldo_reg;
  logic [15:0] dg_cnt_reg;
  logic pg_reg;
  logic [15:0] settle_cnt_reg;
  logic [15:0] blank_cnt_reg;
  logic [15:0] sec_cnt_reg;
  logic sec_tick;
  logic reg_on;
  logic mon_on;
  logic mon_on_d_reg;
  logic reg_on_d_reg;
  logic flags_read;
  logic alert;
  logic ldo_exit;
  logic ot_exit;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; a change counts once stages two and three agree
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      sync1_reg <= 6'h23;
      sync2_reg <= 6'h23;
      sync3_reg <= 6'h23;
      pin_reg <= 6'h23;
    end
    else
    begin
      sync1_reg <= {die_below_110_in, die_above_125_in, host_ldo_uv_ok_in,
        address_select_pin_in, sda_in, scl_in};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      for (int i = 0; i < 6; i++)
        if (sync2_reg[i] == sync3_reg[i])
          pin_reg[i] <= sync3_reg[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Low-frequency tick as one-cycle enable
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
      div_reg <= 16'h0000;
    else if (div_reg == LF_DIV_L)
      div_reg <= 16'h0000;
    else
      div_reg <= div_reg + 16'h0001;
  end

  assign lf_tick = (div_reg == LF_DIV_L);

  ////////////////////////////////////////////////////////////////////////////
  // Register port, address from select pin
  i2c_reg_slave u_slave
  (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .scl_in(pin_reg[PIN_SCL]),
    .sda_in(pin_reg[PIN_SDA]),
    .slave_addr_in(pin_reg[PIN_ASEL] ? I2C_ADDR_HIGH : I2C_ADDR_LOW),
    .rdata_in(rdata),
    .req_out(req),
    .sda_oe_b_out(sda_oe_b_out)
  );

  assign sda_out = 1'b0;
  assign flags_read = req.rd && req.addr == OFS_LATCHED_FAULT_FLAGS;

  ////////////////////////////////////////////////////////////////////////////
  // Effective enables; fault states override programmed ones
  always_comb
  begin
    unique case (state_reg)
      FS_NORMAL:
      begin
        block_enables_a_out = en_a_reg;
        block_enables_b_out = en_b_reg;
      end
      FS_LDO_FAULT:
      begin
        // Amplifiers and drivers off, regulator kept, monitor forced
        block_enables_a_out = 8'h00;
        block_enables_b_out = 8'h00;
        block_enables_b_out[BIT_ENB_HOST_REGULATOR] = 1'b1;
        block_enables_b_out[BIT_ENB_OVERTEMP_MON] = 1'b1;
      end
      FS_OVERTEMP:
      begin
        block_enables_a_out = 8'h00;
        block_enables_b_out = 8'h00;
      end
    endcase
  end

  assign reg_on = block_enables_b_out[BIT_ENB_HOST_REGULATOR];
  assign mon_on = block_enables_b_out[BIT_ENB_OVERTEMP_MON];
  assign host_ldo_vsel_out = ctrl_reg[2:0];
  assign fault_state_out = state_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Power-good deglitch; a level must hold the filter time
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      dg_cnt_reg <= 16'h0000;
      pg_reg <= 1'b0;
    end
    else if (!reg_on)
    begin
      dg_cnt_reg <= 16'h0000; // Monitor runs only with regulator on
      pg_reg <= 1'b0;
    end
    else if (pin_reg[PIN_PG] == pg_reg)
      dg_cnt_reg <= 16'h0000;
    else if (lf_tick)
    begin
      if (dg_cnt_reg + 16'h0001 >= DEGLITCH_L)
      begin
        pg_reg <= pin_reg[PIN_PG];
        dg_cnt_reg <= 16'h0000;
      end
      else
        dg_cnt_reg <= dg_cnt_reg + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Settling after enable or voltage change
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      settle_cnt_reg <= 16'h0000;
      reg_on_d_reg <= 1'b0;
    end
    else
    begin
      reg_on_d_reg <= reg_on;
      if (!reg_on || !reg_on_d_reg || (req.wr && req.addr == OFS_CONTROL_BITS
          && req.wdata[2:0] != ctrl_reg[2:0]))
        settle_cnt_reg <= 16'h0000;
      else if (lf_tick && settle_cnt_reg <= SETTLE_L)
        settle_cnt_reg <= settle_cnt_reg + 16'h0001; // Strictly more than the window
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Overtemp blanking after monitor turn-on
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      blank_cnt_reg <= 16'h0000;
      mon_on_d_reg <= 1'b0;
    end
    else
    begin
      mon_on_d_reg <= mon_on;
      if (!mon_on || !mon_on_d_reg)
        blank_cnt_reg <= 16'h0000;
      else if (lf_tick && blank_cnt_reg < BLANK_L)
        blank_cnt_reg <= blank_cnt_reg + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Once-per-second tick, only inside a fault state
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in || state_reg == FS_NORMAL)
      sec_cnt_reg <= 16'h0000;
    else if (lf_tick)
      sec_cnt_reg <= (sec_cnt_reg == CHECK_L) ? 16'h0000 : sec_cnt_reg + 16'h0001;
  end

  assign sec_tick = lf_tick && sec_cnt_reg == CHECK_L;

  ////////////////////////////////////////////////////////////////////////////
  // Flag set and still-present causes
  always_comb
  begin
    flag_set = {ext_fault_cond_in, 2'b00};
    flag_cond = {ext_fault_cond_in, 2'b00};
    flag_set[BIT_FLAG_OVERTEMP] = mon_on && blank_cnt_reg >= BLANK_L
      && pin_reg[PIN_HOT];
    flag_cond[BIT_FLAG_OVERTEMP] = !pin_reg[PIN_COOL];
    flag_set[BIT_FLAG_HOST_LDO] = reg_on && !pg_reg && settle_cnt_reg > SETTLE_L;
    flag_cond[BIT_FLAG_HOST_LDO] = !pg_reg;
  end

  // Read clears only flags whose cause is gone; a set wins
  assign flags_next = (flags_reg & ~(flags_read ? ~flag_cond : 8'h00)) | flag_set;

  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
      flags_reg <= 8'h00;
    else
      flags_reg <= flags_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Masked flags onto selected pins
  assign alert = |(flags_reg & mask_reg);

  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      gpio_alert_out <= 1'b0;
      rx_pin_alert_out <= 1'b0;
    end
    else
    begin
      gpio_alert_out <= alert && cfg_b_reg[1:0] == GPIO_FUNC_ALERT;
      rx_pin_alert_out <= alert && cfg_a_reg[BIT_CFGA_ALERT_ON_RX];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault state machine
  assign ldo_exit = pg_reg && (sec_tick || flags_read);
  assign ot_exit = pin_reg[PIN_COOL] && (sec_tick || flags_read);

  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      state_reg <= FS_NORMAL;
      from_ldo_reg <= 1'b0;
      saved_a_reg <= 8'h00;
      saved_b_reg <= 8'h00;
    end
    else
    begin
      unique case (state_reg)
        FS_NORMAL:
          if (flag_set[BIT_FLAG_OVERTEMP])
          begin
            state_reg <= FS_OVERTEMP;
            from_ldo_reg <= 1'b0;
            saved_a_reg <= en_a_reg;
            saved_b_reg <= en_b_reg;
          end
          else if (flags_next[BIT_FLAG_HOST_LDO] && !flags_reg[BIT_FLAG_HOST_LDO]
              && !cfg_a_reg[BIT_CFGA_LDO_FAULT_DIS])
          begin
            // Error's rising edge, so a sticky bit cannot re-trap
            state_reg <= FS_LDO_FAULT;
            saved_a_reg <= en_a_reg;
            saved_b_reg <= en_b_reg;
          end
        FS_LDO_FAULT:
          if (flag_set[BIT_FLAG_OVERTEMP])
          begin
            state_reg <= FS_OVERTEMP;
            from_ldo_reg <= 1'b1;
          end
          else if (ldo_exit)
            state_reg <= FS_NORMAL;
        FS_OVERTEMP:
          if (ot_exit)
            state_reg <= from_ldo_reg ? FS_LDO_FAULT : FS_NORMAL;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Writable registers; unmapped offsets are ignored
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      mask_reg <= RST_INTERRUPT_MASK;
      cfg_a_reg <= RST_CONFIGURATION_A;
      cfg_b_reg <= RST_CONFIGURATION_B;
      en_a_reg <= RST_BLOCK_ENABLES_A;
      en_b_reg <= RST_BLOCK_ENABLES_B;
      ctrl_reg <= RST_CONTROL_BITS;
    end
    else if ((state_reg == FS_LDO_FAULT && ldo_exit
        && !flag_set[BIT_FLAG_OVERTEMP]) || (state_reg == FS_OVERTEMP && ot_exit
        && !from_ldo_reg))
    begin
      en_a_reg <= saved_a_reg;
      en_b_reg <= saved_b_reg;
    end
    else if (req.wr)
    begin
      unique case (req.addr)
        OFS_INTERRUPT_MASK: mask_reg <= req.wdata;
        OFS_CONFIGURATION_A: cfg_a_reg <= req.wdata;
        OFS_CONFIGURATION_B: cfg_b_reg <= req.wdata;
        OFS_BLOCK_ENABLES_A: en_a_reg <= req.wdata;
        OFS_BLOCK_ENABLES_B: en_b_reg <= req.wdata;
        OFS_CONTROL_BITS: ctrl_reg <= req.wdata;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped offsets read as zero
  always_comb
  begin
    unique case (req.addr)
      OFS_DEVICE_INFORMATION: rdata = DEVICE_INFO;
      OFS_LATCHED_FAULT_FLAGS: rdata = flags_reg;
      OFS_SECONDARY_FLAGS: rdata = {4'h0, !pin_reg[PIN_COOL], state_reg == FS_OVERTEMP,
        state_reg == FS_LDO_FAULT, pg_reg};
      OFS_INTERRUPT_MASK: rdata = mask_reg;
      OFS_CONFIGURATION_A: rdata = cfg_a_reg;
      OFS_CONFIGURATION_B: rdata = cfg_b_reg;
      OFS_BLOCK_ENABLES_A: rdata = en_a_reg;
      OFS_BLOCK_ENABLES_B: rdata = en_b_reg;
      OFS_CONTROL_BITS: rdata = ctrl_reg;
      default: rdata = 8'h00;
    endcase
  end

endmodule

// >>> test/fault_alert_assertions.sv
// Checks on fault state, enables and alerts
module fault_alert_assertions
(
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic die_above_125_in,
  input wire logic gpio_alert_out,
  input wire logic [7:0] block_enables_a_out,
  input wire logic [7:0] block_enables_b_out,
  input wire fault_alert_pkg::fault_state_t fault_state_out
);
  import fault_alert_pkg::*;
  logic [5:0] mon_cnt;
  logic [7:0] snap_a;
  logic [7:0] snap_b;
  logic from_ldo;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  ////////////////////////////////////////
  // Monitor-on time in normal state, past blanking
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in || !block_enables_b_out[1] || fault_state_out != FS_NORMAL)
      mon_cnt <= 6'h00;
    else if (mon_cnt != 6'h3F)
      mon_cnt <= mon_cnt + 6'h01;
  end
  // Last normal enables; overtemp entered from regulator fault
  always_ff @(posedge sys_clk_in)
  begin
    if (fault_state_out == FS_NORMAL)
    begin
      snap_a <= block_enables_a_out;
      snap_b <= block_enables_b_out;
    end
    if (fault_state_out != FS_OVERTEMP)
      from_ldo <= fault_state_out == FS_LDO_FAULT;
  end
  ////////////////////////////////////////
  AST_RESET_IDLE: assert property (disable iff (1'h0) !rst_b_in |=>
    fault_state_out == FS_NORMAL && !gpio_alert_out && block_enables_b_out == 8'h01)
    else $error("outputs not idle after reset");
  AST_LDO_FAULT_OFF: assert property (
    fault_state_out == FS_LDO_FAULT |-> block_enables_a_out == 8'h00 && block_enables_b_out[1:0] == 2'h3)
    else $error("regulator fault enables wrong");
  AST_OT_ALL_OFF: assert property (
    fault_state_out == FS_OVERTEMP |-> block_enables_a_out == 8'h00 && !block_enables_b_out[0])
    else $error("overtemp left blocks on");
  AST_OT_NEEDS_MON: assert property (
    fault_state_out == FS_NORMAL && !block_enables_b_out[1] |=> fault_state_out != FS_OVERTEMP)
    else $error("overtemp with monitor off");
  AST_OT_DETECT: assert property (
    mon_cnt == 6'h3F && die_above_125_in |-> ##[1:8] fault_state_out == FS_OVERTEMP)
    else $error("overtemp not detected");
  AST_EXIT_RESTORE: assert property (
    $past(fault_state_out) != FS_NORMAL && fault_state_out == FS_NORMAL |->
    block_enables_a_out == snap_a && block_enables_b_out == snap_b)
    else $error("enables not restored");
  AST_OT_RETURN: assert property (
    $past(fault_state_out) == FS_OVERTEMP && fault_state_out != FS_OVERTEMP |->
    fault_state_out == (from_ldo ? FS_LDO_FAULT : FS_NORMAL))
    else $error("wrong state after overtemp");
  AST_ALERT_HOLD: assert property (
    $rose(gpio_alert_out) |=> gpio_alert_out [*8])
    else $error("alert dropped early");
endmodule

bind fault_alert_supervisor fault_alert_assertions u_chk (.sys_clk_in(sys_clk_in),
  .rst_b_in(rst_b_in), .die_above_125_in(die_above_125_in), .gpio_alert_out(gpio_alert_out),
  .block_enables_a_out(block_enables_a_out), .block_enables_b_out(block_enables_b_out),
  .fault_state_out(fault_state_out));

// >>> test/host_i2c_model.sv
// Host model: bit-level two-wire master
module host_i2c_model
(
  input wire logic sys_clk_in,
  input wire logic sda_line_in,
  output logic scl_out,
  output logic sda_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Bus idles released, both lines high
  initial
  begin
    scl_out = 1'h1;
    sda_out = 1'h1;
  end
  // Six clocks a phase, clear of the synchronisers
  task automatic put(input logic d, input logic c);
    @(posedge sys_clk_in);
    sda_out <= d;
    scl_out <= c;
    repeat (5) @(posedge sys_clk_in);
  endtask
  // Nine bits MSB first; data moves while clock low
  task automatic xfer(input logic [8:0] d, output logic [8:0] r);
    for (int i = 8; i >= 0; i--)
    begin
      put(d[i], 1'h0);
      put(d[i], 1'h1);
      r[i] = sda_line_in;
      put(d[i], 1'h0);
    end
  endtask
  // Start, address, n bytes, stop
  task automatic txn(input logic [6:0] a, input logic rd, input logic [15:0] w, input int n,
                     output logic [7:0] q, output logic nak);
    logic [8:0] r;
    put(1'h1, 1'h1);
    put(1'h0, 1'h1);
    put(1'h0, 1'h0);
    xfer({a, rd, 1'h1}, r);
    nak = r[0];
    for (int i = 0; i < n; i++)
    begin
      xfer(rd ? 9'h1FF : {w[15 - 8 * i -: 8], 1'h1}, r);
      q = r[8:1];
      nak = nak | (!rd & r[0]);
    end
    put(1'h0, 1'h0);
    put(1'h0, 1'h1);
    put(1'h1, 1'h1);
  endtask
endmodule

// >>> test/tb_fault_alert_supervisor.sv
// Bench for the fault alert supervisor
module tb_fault_alert_supervisor;
  timeunit 1ns;
  timeprecision 1ns;
  import fault_alert_pkg::*;
  localparam logic [7:0] DEV = 8'hC3; // Arbitrary identification value
  logic sys_clk = 1'h0, rst_b = 1'h0, asel = 1'h0, pg = 1'h1, hot = 1'h0, cool = 1'h1;
  logic [5:0] ext = 6'h00;
  logic scl, sda_h, sda_o, sda_oe_b, gpio, rx, nak;
  logic [7:0] ena, enb, q, d;
  logic [2:0] vsel;
  fault_state_t st;
  logic [6:0] addr = I2C_ADDR_LOW;
  logic [7:0] exp_q[$], obs_q[$];
  logic [7:0] rv[10] = '{DEV, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
  logic [7:0] wo[7] = '{8'h00, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08};
  int n_mismatch = 0, check_count = 0, seed = 41038;
  wire sda_line = sda_h & (sda_oe_b | sda_o);
  fault_alert_supervisor #(.LF_DIV(2), .SETTLE_TICKS(12), .CHECK_TICKS(1000), .DEVICE_INFO(DEV))
  u_dut (.sys_clk_in(sys_clk), .rst_b_in(rst_b), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_o), .sda_oe_b_out(sda_oe_b), .address_select_pin_in(asel),
    .host_ldo_uv_ok_in(pg), .die_above_125_in(hot), .die_below_110_in(cool),
    .ext_fault_cond_in(ext), .gpio_alert_out(gpio), .rx_pin_alert_out(rx),
    .block_enables_a_out(ena), .block_enables_b_out(enb), .host_ldo_vsel_out(vsel),
    .fault_state_out(st));
  host_i2c_model u_host (.sys_clk_in(sys_clk), .sda_line_in(sda_line), .scl_out(scl),
    .sda_out(sda_h));
  // 10 MHz system clock
  always #50 sys_clk = ~sys_clk;
  task automatic chk(input logic [7:0] e, input logic [7:0] o);
    exp_q.push_back(e);
    obs_q.push_back(o);
  endtask
  task automatic pt(input logic [7:0] a);
    u_host.txn(addr, 1'h0, {a, 8'h00}, 1, q, nak);
  endtask
  task automatic rd(input logic [7:0] e);
    u_host.txn(addr, 1'h1, 16'h0000, 1, q, nak);
    chk(e, q);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    u_host.txn(addr, 1'h0, {a, v}, 2, q, nak);
    chk(8'h00, {7'h00, nak});
  endtask
  // Settle, then state, alerts and enables
  task automatic see(input logic [3:0] e, input logic [7:0] a, input logic [7:0] b);
    repeat (40) @(posedge sys_clk);
    chk({4'h0, e}, {4'h0, st, gpio, rx});
    chk(a, ena);
    chk(b, enb);
  endtask
  task automatic summarize();
    if (n_mismatch == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Oldest note against oldest observation
  always @(negedge sys_clk)
    while (obs_q.size() > 0)
    begin
      check_count++;
      if (obs_q[0] !== exp_q[0])
      begin
        n_mismatch++;
        $display("MISMATCH t=%0t exp=%h got=%h", $time, exp_q[0], obs_q[0]);
      end
      void'(exp_q.pop_front());
      void'(obs_q.pop_front());
    end
  // Watchdog, twice the expected run
  initial
  begin
    repeat (60000) @(posedge sys_clk);
    n_mismatch++;
    summarize();
  end
  ////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'h1;
    repeat (20) @(posedge sys_clk);
    pt(8'h00);
    foreach (rv[i]) rd(rv[i]);
    // Random writes; read-only place keeps its value
    foreach (wo[i])
    begin
      d = 8'($random(seed));
      wr(wo[i], d);
      pt(wo[i]);
      rd(wo[i] == 8'h00 ? DEV : d);
    end
    chk({5'h00, d[2:0]}, {5'h00, vsel});
    wr(8'h04, 8'h01);
    wr(8'h05, 8'h02);
    wr(8'h03, 8'h04);
    wr(8'h06, 8'hA5);
    wr(8'h07, 8'h03);
    ext <= 6'h02;
    see(4'h0, 8'hA5, 8'h03);
    ext <= 6'h03;
    see(4'h3, 8'hA5, 8'h03);
    ext <= 6'h02;
    see(4'h3, 8'hA5, 8'h03);
    pt(8'h01);
    rd(8'h0C);
    see(4'h0, 8'hA5, 8'h03);
    pt(8'h01);
    rd(8'h08);
    wr(8'h05, 8'h01);
    ext <= 6'h01;
    see(4'h1, 8'hA5, 8'h03);
    wr(8'h04, 8'h00);
    see(4'h0, 8'hA5, 8'h03);
    ext <= 6'h00;
    pt(8'h01);
    rd(8'h0C);
    // Overtemp from normal; exit needs a cool die
    hot <= 1'h1;
    cool <= 1'h0;
    see(4'h8, 8'h00, 8'h00);
    hot <= 1'h0;
    pt(8'h01);
    rd(8'h01);
    see(4'h8, 8'h00, 8'h00);
    cool <= 1'h1;
    pt(8'h01);
    rd(8'h01);
    see(4'h0, 8'hA5, 8'h03);
    // Undervoltage, nested overtemp, both exits
    pg <= 1'h0;
    see(4'h4, 8'h00, 8'h03);
    pt(8'h02);
    rd(8'h02);
    hot <= 1'h1;
    cool <= 1'h0;
    see(4'h8, 8'h00, 8'h00);
    hot <= 1'h0;
    cool <= 1'h1;
    repeat (2000) @(posedge sys_clk);
    see(4'h4, 8'h00, 8'h03);
    pg <= 1'h1;
    pt(8'h01);
    rd(8'h03);
    see(4'h0, 8'hA5, 8'h03);
    pg <= 1'h0;
    see(4'h4, 8'h00, 8'h03);
    pg <= 1'h1;
    repeat (2100) @(posedge sys_clk);
    see(4'h0, 8'hA5, 8'h03);
    pt(8'h01);
    rd(8'h02);
    // Select high: old address refused
    asel <= 1'h1;
    repeat (10) @(posedge sys_clk);
    u_host.txn(addr, 1'h0, 16'h0000, 0, q, nak);
    chk(8'h01, {7'h00, nak});
    addr = I2C_ADDR_HIGH;
    pt(8'h00);
    rd(DEV);
    repeat (2) @(posedge sys_clk);
    summarize();
  end
endmodule
